/* hw/csr_regs.svh */
// constants for the cpu system register set: numbers, field positions, widths
// assumes the pipeline selects registers by a 5-bit system register number
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH
`define CSR_NUM_IRQ_PC      5'h00
`define CSR_NUM_IRQ_ST      5'h01
`define CSR_NUM_NMI_PC      5'h02
`define CSR_NUM_NMI_ST      5'h03
`define CSR_NUM_EXC_SRC     5'h04
`define CSR_NUM_PSW         5'h05
`define CSR_NUM_CT_PC       5'h10
`define CSR_NUM_CT_ST       5'h11
`define CSR_NUM_TRAP_PC     5'h12
`define CSR_NUM_TRAP_ST     5'h13
`define CSR_NUM_CT_BASE     5'h14
`define CSR_PC_BITS         26
`define CSR_ST_BITS         8
`define CSR_BIT_NP          7
`define CSR_BIT_EP          6
`define CSR_BIT_ID          5
`define CSR_BIT_SAT         4
`define CSR_BIT_CY          3
`define CSR_BIT_OV          2
`define CSR_BIT_S           1
`define CSR_BIT_Z           0
`define CSR_PSW_RESET       8'h20
`define CSR_SAT_POS_MAX     32'h7FFFFFFF
`define CSR_SAT_NEG_MAX     32'h80000000
`endif

/* hw/csr_pkg.sv */
// types for the cpu system register set
// assumes csr_regs.svh is included by the design file
package csr_pkg;
  // one arithmetic result with its flags from the execute stage
  typedef struct packed {
    logic       valid;
    logic       is_sat;
    logic [3:0] flags;
  } csr_alu_t;
  // one system register access from the pipeline
  typedef struct packed {
    logic        wr;
    logic [4:0]  num;
    logic [31:0] data;
  } csr_acc_t;
  // event that saves or restores status
  typedef enum logic [2:0] {
    CSR_EV_NONE, CSR_EV_IRQ, CSR_EV_NMI, CSR_EV_CALL, CSR_EV_TRAP, CSR_EV_INTERRUPT_RETURN, CSR_EV_DEBUG_RETURN
  } csr_ev_t;
endpackage : csr_pkg

/* hw/csr_regset.sv */
// the cpu system register set: save pairs, source, status word, call base
// assumes the pipeline gives one event and one access per ref_clk edge
`include "csr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module csr_regset #(
  parameter int EXC_W = 32
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // save and restore events
  input  wire csr_pkg::csr_ev_t  event_kind,
  input  wire logic [31:0]       next_pc_in,
  input  wire logic [EXC_W-1:0]  exc_code_in,
  // system register access
  input  wire csr_pkg::csr_acc_t acc,
  // arithmetic results
  input  wire csr_pkg::csr_alu_t alu,
  // interrupt request
  input  wire logic              irq_req,
  // outputs
  output logic [31:0]            rd_data,
  output logic [31:0]            restore_pc,
  output logic                   restore_valid,
  output logic [31:0]            status_word,
  output logic                   irq_ack_ok,
  output logic                   nmi_active
);
  // register storage, only meaningful bits kept; upper bits read as zero
  logic [25:0]      irq_saved_pc;             // pc saved on maskable entry
  logic [7:0]       irq_saved_status;         // status saved on maskable entry
  logic [25:0]      nmi_saved_pc;             // pc saved on nmi entry
  logic [7:0]       nmi_saved_status;         // status saved on nmi entry
  logic [25:0]      table_call_saved_pc;      // pc saved by a table call
  logic [7:0]       table_call_saved_status;  // status saved by a table call
  logic [25:0]      trap_saved_pc;            // pc saved on a trap
  logic [7:0]       trap_saved_status;        // status saved on a trap
  logic [25:0]      table_call_base;          // table call base, bit zero low
  logic [7:0]       program_status_word;      // live status flags
  logic [EXC_W-1:0] exception_source;         // code of the last entry
  logic             in_debug;                 // between trap entry and debug return

  // zero-extend helpers
  function automatic logic [31:0] ext_pc(input logic [25:0] v);
    ext_pc = {6'h00, v};
  endfunction : ext_pc
  function automatic logic [31:0] ext_st(input logic [7:0] v);
    ext_st = {24'h000000, v};
  endfunction : ext_st

  // decode of writes
  wire ld   = acc.wr;
  wire w_ipc = ld && acc.num == `CSR_NUM_IRQ_PC;
  wire w_ist = ld && acc.num == `CSR_NUM_IRQ_ST;
  wire w_npc = ld && acc.num == `CSR_NUM_NMI_PC;
  wire w_nst = ld && acc.num == `CSR_NUM_NMI_ST;
  wire w_psw = ld && acc.num == `CSR_NUM_PSW;
  wire w_cpc = ld && acc.num == `CSR_NUM_CT_PC;
  wire w_cst = ld && acc.num == `CSR_NUM_CT_ST;
  wire w_tpc = ld && in_debug && acc.num == `CSR_NUM_TRAP_PC;
  wire w_tst = ld && in_debug && acc.num == `CSR_NUM_TRAP_ST;
  wire w_cbp = ld && acc.num == `CSR_NUM_CT_BASE;
  wire [25:0] wpc = acc.data[25:0];
  wire [7:0]  wst = acc.data[7:0];

  // read selection by number; reserved and upper bits zero
  logic [31:0] next_rd;
  always_comb begin
    unique case (acc.num)
      `CSR_NUM_IRQ_PC:  next_rd = ext_pc(irq_saved_pc);
      `CSR_NUM_IRQ_ST:  next_rd = ext_st(irq_saved_status);
      `CSR_NUM_NMI_PC:  next_rd = ext_pc(nmi_saved_pc);
      `CSR_NUM_NMI_ST:  next_rd = ext_st(nmi_saved_status);
      `CSR_NUM_EXC_SRC: next_rd = 32'(exception_source);
      `CSR_NUM_PSW:     next_rd = ext_st(program_status_word);
      `CSR_NUM_CT_PC:   next_rd = ext_pc(table_call_saved_pc);
      `CSR_NUM_CT_ST:   next_rd = ext_st(table_call_saved_status);
      `CSR_NUM_TRAP_PC: next_rd = in_debug ? ext_pc(trap_saved_pc) : 32'h00000000;
      `CSR_NUM_TRAP_ST: next_rd = in_debug ? ext_st(trap_saved_status) : 32'h00000000;
      `CSR_NUM_CT_BASE: next_rd = ext_pc(table_call_base);
      default:          next_rd = 32'h00000000;
    endcase
  end

  // event decode
  wire ev_irq  = event_kind == csr_pkg::CSR_EV_IRQ;
  wire ev_nmi  = event_kind == csr_pkg::CSR_EV_NMI;
  wire ev_call = event_kind == csr_pkg::CSR_EV_CALL;
  wire ev_trap = event_kind == csr_pkg::CSR_EV_TRAP;
  wire ev_interrupt_return = event_kind == csr_pkg::CSR_EV_INTERRUPT_RETURN;
  wire ev_dbr  = event_kind == csr_pkg::CSR_EV_DEBUG_RETURN;
  wire psw_np  = program_status_word[`CSR_BIT_NP];

  // interrupt return picks nmi pair when nmi flag set
  wire [25:0] interrupt_return_pc = psw_np ? nmi_saved_pc : irq_saved_pc;
  wire [7:0]  interrupt_return_st = psw_np ? nmi_saved_status : irq_saved_status;
  wire [25:0] rest_pc = ev_dbr ? trap_saved_pc : interrupt_return_pc;
  wire [31:0] next_restore_pc = ext_pc({rest_pc[25:1], 1'b0});

  // flag merge from an arithmetic result
  wire sat_hit = alu.valid && alu.is_sat && alu.flags[2];
  wire [7:0] alu_psw = {program_status_word[7:5],
                        program_status_word[`CSR_BIT_SAT] | sat_hit,
                        alu.flags};

  // next status word by priority: events, then load write, then alu
  logic [7:0] next_psw;
  always_comb begin
    next_psw = program_status_word;
    if (ev_interrupt_return) begin
      next_psw = interrupt_return_st;
    end else if (ev_dbr) begin
      next_psw = trap_saved_status;
    end else if (ev_nmi) begin
      next_psw = program_status_word | 8'hA0;
    end else if (ev_irq || ev_trap) begin
      // exception flag set, disable set for the handler
      next_psw = program_status_word | 8'h60;
    end else if (w_psw) begin
      // load write replaces all flags, sticky takes the written bit
      next_psw = wst;
    end else if (alu.valid) begin
      next_psw = alu_psw;
    end
  end

  // status word register; the outside copy follows the same next value
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      program_status_word <= `CSR_PSW_RESET;
      status_word         <= 32'h00000020;
      nmi_active          <= 1'b0;
    end else begin
      program_status_word <= next_psw;
      // a load write shows at the very next edge
      status_word         <= ext_st(next_psw);
      // nmi in service mirrors its status bit
      nmi_active          <= next_psw[`CSR_BIT_NP];
    end
  end

  // read data for the number on the access bus, one edge later
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= next_rd;
    end
  end

  // restore address and its one-cycle strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      restore_pc    <= 32'h00000000;
      restore_valid <= 1'b0;
    end else begin
      restore_pc    <= next_restore_pc;
      restore_valid <= ev_interrupt_return || ev_dbr;
    end
  end

  // no ack while disable set or being set
  wire next_ack = irq_req && !next_psw[`CSR_BIT_ID] && !next_psw[`CSR_BIT_NP]
                  && !(w_psw && wst[`CSR_BIT_ID]);
  // acknowledge permission towards the interrupt controller
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ack_ok <= 1'b0;
    end else begin
      irq_ack_ok <= next_ack;
    end
  end

  // maskable interrupt pair, saved on irq entry only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_saved_pc     <= 26'h0000000;
      irq_saved_status <= 8'h00;
    end else if (ev_irq) begin
      // entry capture wins over a load write in the same cycle
      irq_saved_pc     <= next_pc_in[25:0];
      irq_saved_status <= program_status_word;
    end else begin
      // load writes land field by field
      if (w_ipc) begin
        irq_saved_pc <= wpc;
      end
      if (w_ist) begin
        irq_saved_status <= wst;
      end
    end
  end

  // nmi pair, kept apart from the maskable pair
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_saved_pc     <= 26'h0000000;
      nmi_saved_status <= 8'h00;
    end else if (ev_nmi) begin
      // entry capture wins over a load write in the same cycle
      nmi_saved_pc     <= next_pc_in[25:0];
      nmi_saved_status <= program_status_word;
    end else begin
      // load writes land field by field
      if (w_npc) begin
        nmi_saved_pc <= wpc;
      end
      if (w_nst) begin
        nmi_saved_status <= wst;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      table_call_saved_pc     <= 26'h0000000;
      table_call_saved_status <= 8'h00;
    end else if (ev_call) begin
      // the call saves the address after itself
      table_call_saved_pc     <= next_pc_in[25:0];
      table_call_saved_status <= program_status_word;
    end else begin
      // load writes land field by field
      if (w_cpc) begin
        table_call_saved_pc <= wpc;
      end
      if (w_cst) begin
        table_call_saved_status <= wst;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trap_saved_pc     <= 26'h0000000;
      trap_saved_status <= 8'h00;
    end else if (ev_trap) begin
      // entry capture wins over a load write in the same cycle
      trap_saved_pc     <= next_pc_in[25:0];
      trap_saved_status <= program_status_word;
    end else begin
      // load writes only reach here inside the debug window
      if (w_tpc) begin
        trap_saved_pc <= wpc;
      end
      if (w_tst) begin
        trap_saved_status <= wst;
      end
    end
  end

  // base pointer bit zero held low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      table_call_base <= 26'h0000000;
    end else if (w_cbp) begin
      table_call_base <= {wpc[25:1], 1'b0};
    end
  end

  // source changes only on entries, never by a load write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      exception_source <= '0;
    end else if (ev_irq || ev_nmi || ev_trap) begin
      exception_source <= exc_code_in;
    end
  end

  // debug window opens at a trap and closes at debug return
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_debug <= 1'b0;
    end else if (ev_trap) begin
      in_debug <= 1'b1;
    end else if (ev_dbr) begin
      in_debug <= 1'b0;
    end
  end

  // checks
  chk_src_readonly: assert property (@(posedge ref_clk) disable iff (!nrst)
    (acc.wr && acc.num == `CSR_NUM_EXC_SRC && event_kind == csr_pkg::CSR_EV_NONE)
      |=> $stable(exception_source)) else $error("source changed by load");
  chk_restore_even: assert property (@(posedge ref_clk) disable iff (!nrst)
    restore_valid |-> restore_pc[0] == 1'b0 && restore_pc[31:26] == 6'h00)
    else $error("restored pc odd or wide");
  chk_nmi_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_nmi |=> program_status_word[`CSR_BIT_NP] && nmi_active)
    else $error("nmi flag not set");
  chk_irq_save_pc: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_irq |=> irq_saved_pc == $past(next_pc_in[25:0]) &&
      irq_saved_status == $past(program_status_word)) else $error("irq save wrong");
  chk_nmi_save_pc: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_nmi |=> nmi_saved_pc == $past(next_pc_in[25:0]) && $stable(irq_saved_pc))
    else $error("nmi save wrong");
  chk_no_ack_disabled: assert property (@(posedge ref_clk) disable iff (!nrst)
    program_status_word[`CSR_BIT_ID] && !w_psw && !ev_interrupt_return && !ev_dbr |=> !irq_ack_ok)
    else $error("ack while disabled");
  chk_ack_load_disable: assert property (@(posedge ref_clk) disable iff (!nrst)
    (w_psw && wst[`CSR_BIT_ID]) |=> !irq_ack_ok) else $error("ack during disable load");
  chk_sat_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
    program_status_word[`CSR_BIT_SAT] && event_kind == csr_pkg::CSR_EV_NONE && !w_psw
      |=> program_status_word[`CSR_BIT_SAT]) else $error("sticky flag lost");
  chk_sat_needs_ov: assert property (@(posedge ref_clk) disable iff (!nrst)
    (alu.valid && alu.is_sat && !alu.flags[2] && !program_status_word[`CSR_BIT_SAT]
      && event_kind == csr_pkg::CSR_EV_NONE && !w_psw) |=> !program_status_word[`CSR_BIT_SAT])
    else $error("sat without overflow");
  chk_trap_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!in_debug && acc.wr && acc.num == `CSR_NUM_TRAP_PC && !ev_trap) |=> $stable(trap_saved_pc))
    else $error("trap pc written outside debug");
  chk_base_even: assert property (@(posedge ref_clk) disable iff (!nrst)
    w_cbp |=> table_call_base[0] == 1'b0 ##1 table_call_base[0] == 1'b0)
    else $error("base odd");
  // save, restore, status and read checks
  chk_call_save: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_call |=> table_call_saved_pc == $past(next_pc_in[25:0]) &&
      table_call_saved_status == $past(program_status_word)) else $error("call save wrong");
  chk_trap_save: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_trap |=> trap_saved_pc == $past(next_pc_in[25:0]) && in_debug &&
      trap_saved_status == $past(program_status_word)) else $error("trap save wrong");
  chk_debug_return_restore: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_dbr |=> restore_valid && restore_pc[25:1] == $past(trap_saved_pc[25:1]) &&
      status_word[7:0] == $past(trap_saved_status)) else $error("debug return wrong");
  chk_interrupt_return_irq_pair: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_interrupt_return && !psw_np |=> restore_valid && restore_pc[25:1] == $past(irq_saved_pc[25:1]) &&
      status_word[7:0] == $past(irq_saved_status)) else $error("irq return wrong");
  chk_interrupt_return_nmi_pair: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_interrupt_return && psw_np |=> restore_valid && restore_pc[25:1] == $past(nmi_saved_pc[25:1]) &&
      status_word[7:0] == $past(nmi_saved_status)) else $error("nmi return wrong");
  chk_entry_ep_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ev_irq || ev_trap) |=> program_status_word[`CSR_BIT_EP]) else $error("progress flag low");
  chk_status_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    (w_psw && event_kind == csr_pkg::CSR_EV_NONE) |=> status_word[7:0] == $past(acc.data[7:0]))
    else $error("status write late");
  chk_read_upper_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (acc.num != `CSR_NUM_EXC_SRC) |=> rd_data[31:26] == 6'h00 && status_word[31:8] == 24'h000000)
    else $error("upper bits set");
  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    ((acc.num > `CSR_NUM_PSW && acc.num < `CSR_NUM_CT_PC) || acc.num > `CSR_NUM_CT_BASE)
      |=> rd_data == 32'h00000000) else $error("reserved number reads data");
endmodule : csr_regset
`default_nettype wire

/* sim/csr_pipe_model.sv */
// pipeline model: drives events, register accesses and results into the set
// assumes the bench calls op once per operation, never from two processes
`timescale 1ns/1ps
`default_nettype none
module csr_pipe_model (
  // clock
  input  wire logic              ref_clk,
  // drive towards the register set
  output var csr_pkg::csr_ev_t   event_kind,
  output var logic [31:0]        next_pc_in,
  output var logic [31:0]        exc_code_in,
  output var csr_pkg::csr_acc_t  acc,
  output var csr_pkg::csr_alu_t  alu,
  output var logic               irq_req
);
  // idle values at time zero; a request stays pending all run
  initial begin
    event_kind  = csr_pkg::CSR_EV_NONE;
    next_pc_in  = 32'h0;
    exc_code_in = 32'h0;
    acc         = '0;
    alu         = '0;
    irq_req     = 1'b1;
  end
  // software-side access pattern
  // one operation held for one edge, then idle; data lines flip when idle
  task automatic op(input csr_pkg::csr_ev_t ev, input logic wr, input logic [4:0] num,
                    input logic [31:0] d, input logic [5:0] al);
    @(posedge ref_clk);
    event_kind  <= ev;
    next_pc_in  <= d;
    exc_code_in <= ~d;
    acc         <= {wr, num, d};
    alu         <= csr_pkg::csr_alu_t'(al);
    @(posedge ref_clk);
    event_kind  <= csr_pkg::CSR_EV_NONE;
    next_pc_in  <= ~d;
    acc         <= {1'b0, 5'h1F, ~d};
    alu         <= '0;
    #1;
  endtask : op
endmodule : csr_pipe_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the cpu system register set
// assumes csr_pkg is compiled first and the pipeline model drives all inputs but clock and reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // clock, reset and wiring
  logic              ref_clk;
  logic              nrst;
  csr_pkg::csr_ev_t  event_kind;
  logic [31:0]       next_pc_in;
  logic [31:0]       exc_code_in;
  csr_pkg::csr_acc_t acc;
  csr_pkg::csr_alu_t alu;
  logic              irq_req;
  logic [31:0]       rd_data;
  logic [31:0]       restore_pc;
  logic              restore_valid;
  logic [31:0]       status_word;
  logic              irq_ack_ok;
  logic              nmi_active;
  int                checks;
  int                fail_count;
  // event shorthands
  localparam csr_pkg::csr_ev_t ev_no = csr_pkg::CSR_EV_NONE;
  localparam csr_pkg::csr_ev_t ev_ret = csr_pkg::CSR_EV_INTERRUPT_RETURN;
  csr_pipe_model pm (.ref_clk(ref_clk), .event_kind(event_kind), .next_pc_in(next_pc_in),
    .exc_code_in(exc_code_in), .acc(acc), .alu(alu), .irq_req(irq_req));
  csr_regset dut (.ref_clk(ref_clk), .nrst(nrst), .event_kind(event_kind),
    .next_pc_in(next_pc_in), .exc_code_in(exc_code_in), .acc(acc), .alu(alu),
    .irq_req(irq_req), .rd_data(rd_data), .restore_pc(restore_pc),
    .restore_valid(restore_valid), .status_word(status_word), .irq_ack_ok(irq_ack_ok),
    .nmi_active(nmi_active));
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // compare one value
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // verdict and end of run
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // bus helpers
  task automatic wr(input logic [4:0] n, input logic [31:0] d);
    pm.op(ev_no, 1'b1, n, d, 6'h00);
  endtask : wr
  task automatic rd(input logic [4:0] n, input logic [31:0] ex);
    pm.op(ev_no, 1'b0, n, 32'h0, 6'h00);
    chk("rd_data", ex, rd_data);
  endtask : rd
  // masking, read-only, reserved and base pointer
  task automatic t_regs;
    chk("status_word", 32'h00000020, status_word);
    wr(5'h00, 32'hFFFFFFFF);
    rd(5'h00, 32'h03FFFFFF);
    wr(5'h01, 32'hFFFFFFFF);
    rd(5'h01, 32'h000000FF);
    wr(5'h04, 32'h5A5A5A5A);
    rd(5'h04, 32'h00000000);
    wr(5'h06, 32'h12345678);
    rd(5'h06, 32'h00000000);
    wr(5'h15, 32'h12345678);
    rd(5'h15, 32'h00000000);
    wr(5'h14, 32'hFFFFFFFF);
    rd(5'h14, 32'h03FFFFFE);
    wr(5'h10, 32'hFFFFFFFF);
    rd(5'h10, 32'h03FFFFFF);
    wr(5'h12, 32'h0000AAAA);
    rd(5'h12, 32'h00000000);
  endtask : t_regs
  // maskable interrupt save, mask and return
  task automatic t_irq;
    wr(5'h05, 32'h0);
    chk("status_word", 32'h0, status_word);
    rd(5'h05, 32'h0);
    chk("irq_ack_ok", 32'h1, {31'h0, irq_ack_ok});
    pm.op(csr_pkg::CSR_EV_IRQ, 1'b0, 5'h0, 32'hFC001235, 6'h00);
    chk("status_word", 32'h60, status_word);
    rd(5'h00, 32'h00001235);
    chk("irq_ack_ok", 32'h0, {31'h0, irq_ack_ok});
    rd(5'h01, 32'h0);
    rd(5'h04, 32'h03FFEDCA);
    pm.op(ev_ret, 1'b0, 5'h0, 32'h0, 6'h00);
    chk("restore_valid", 32'h1, {31'h0, restore_valid});
    chk("restore_pc", 32'h00001234, restore_pc);
    chk("status_word", 32'h0, status_word);
  endtask : t_irq
  // nmi uses its own pair and return picks it
  task automatic t_nmi;
    pm.op(csr_pkg::CSR_EV_NMI, 1'b0, 5'h0, 32'h00000100, 6'h00);
    chk("status_word", 32'hA0, status_word);
    chk("nmi_active", 32'h1, {31'h0, nmi_active});
    rd(5'h02, 32'h00000100);
    rd(5'h03, 32'h0);
    rd(5'h00, 32'h00001235);
    pm.op(ev_ret, 1'b0, 5'h0, 32'h0, 6'h00);
    chk("restore_pc", 32'h00000100, restore_pc);
    chk("status_word", 32'h0, status_word);
  endtask : t_nmi
  // trap window, debug return, then table call
  task automatic t_trap;
    wr(5'h05, 32'h08);
    pm.op(csr_pkg::CSR_EV_TRAP, 1'b0, 5'h0, 32'h00002468, 6'h00);
    chk("status_word", 32'h68, status_word);
    rd(5'h12, 32'h00002468);
    rd(5'h13, 32'h08);
    wr(5'h12, 32'h00001357);
    rd(5'h12, 32'h00001357);
    pm.op(csr_pkg::CSR_EV_DEBUG_RETURN, 1'b0, 5'h0, 32'h0, 6'h00);
    chk("restore_pc", 32'h00001356, restore_pc);
    chk("status_word", 32'h08, status_word);
    rd(5'h12, 32'h0);
    pm.op(csr_pkg::CSR_EV_CALL, 1'b0, 5'h0, 32'h00003333, 6'h00);
    rd(5'h10, 32'h00003333);
    rd(5'h11, 32'h08);
  endtask : t_trap
  // saturation flag patterns, stickiness and clearing; disable on load
  task automatic t_sat;
    wr(5'h05, 32'h0);
    pm.op(ev_no, 1'b0, 5'h0, 32'h0, 6'h36);
    chk("status_word", 32'h16, status_word);
    pm.op(ev_no, 1'b0, 5'h0, 32'h0, 6'h20);
    chk("status_word", 32'h10, status_word);
    pm.op(ev_no, 1'b0, 5'h0, 32'h0, 6'h32);
    chk("status_word", 32'h12, status_word);
    pm.op(ev_no, 1'b0, 5'h0, 32'h0, 6'h34);
    chk("status_word", 32'h14, status_word);
    wr(5'h05, 32'h0);
    chk("status_word", 32'h0, status_word);
    wr(5'h05, 32'h20);
    chk("irq_ack_ok", 32'h0, {31'h0, irq_ack_ok});
  endtask : t_sat
  // main sequence: 10-cycle reset then scenarios
  initial begin
    checks     = 0;
    fail_count = 0;
    nrst       = 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    t_regs();
    t_irq();
    t_nmi();
    t_trap();
    t_sat();
    end_of_test();
  end
  // watchdog against a hang
  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
